// ===== hdl/osd_offset_and_memory_mode_regs.sv
// Overlay position offset registers and display memory mode register,
// reached over the serial port, with the display memory write strobes.
// Assumes serial pins are asynchronous; video timing and memory signals share core_clk.

`timescale 1ns/100ps

// Contract
// - The horizontal offset register is written at 0x02 and read at 0x82 without restriction.
// - Field bits 5..0: 0 is 32 pixels left, 0x20 (reset) no shift, 0x3f 31 pixels right.
// - Overlay pixels are never inserted during horizontal blanking, whatever the offset.
// - The vertical offset register is written at 0x03 and read at 0x83 without restriction.
// - Its 5-bit field in bits 4..0 resets to 0x10, and code 0 moves the overlay 16 lines up.
// - The vertical offset may move overlay rows into the vertical blanking lines.
// - The display memory mode register is written at 0x04 and read at 0x84.
// - A mode register write takes effect only while the clear-busy bit 2 reads zero.
// - Mode bit 6 selects 16-bit operation at 0 and 8-bit operation at 1, resetting to 0.
// - In 16-bit mode each character write also stores mode bits 5..3 as its attribute.
// - In 16-bit mode a memory read returns the character byte and then the attribute byte.
// - 8-bit mode memory writes go to the character byte, or with byte select 1 the attribute.
// - Copied attribute bits mean local background, blink and invert for bits 5, 4 and 3.
module osd_offset_and_memory_mode_regs
  import osd_regs_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Serial port pins
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              sdin,
  output logic                   sdout_q,
  output logic                   sdout_oe_n_q,
  // Display memory side
  input  wire logic              dm_clear_busy,
  input  wire logic              addr_high_byte_sel,
  input  wire logic [7:0]        dm_rd_char,
  input  wire logic [7:0]        dm_rd_attr,
  output logic                   dm_char_we_q,
  output logic                   dm_attr_we_q,
  output logic [7:0]             dm_char_data_q,
  output logic [7:0]             dm_attr_data_q,
  // Video timing side
  input  wire logic              hblank,
  input  wire logic              osd_pixel,
  output logic                   osd_pixel_en_q,
  output logic signed [6:0]      h_offset_px_q,
  output logic signed [5:0]      v_offset_ln_q,
  // Mode state
  output logic                   eight_bit_mode_q,
  output logic                   local_background_bit_q,
  output logic                   blink_attr_bit_q,
  output logic                   invert_attr_bit_q
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_s1_q;
  logic [PIN_COUNT-1:0] pin_s2_q;
  logic [PIN_COUNT-1:0] pin_s3_q;
  logic [PIN_COUNT-1:0] pin_q;
  logic [PIN_COUNT-1:0] pin_prev_q;

  assign pin_raw = {sdin, sclk, cs_n};

  // A change counts once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          pin_s1_q[gi]   <= (gi == PIN_CS);
          pin_s2_q[gi]   <= (gi == PIN_CS);
          pin_s3_q[gi]   <= (gi == PIN_CS);
          pin_q[gi]      <= (gi == PIN_CS);
          pin_prev_q[gi] <= (gi == PIN_CS);
        end else begin
          pin_s1_q[gi]   <= pin_raw[gi];
          pin_s2_q[gi]   <= pin_s1_q[gi];
          pin_s3_q[gi]   <= pin_s2_q[gi];
          pin_prev_q[gi] <= pin_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic frame_active;
  logic sclk_rise;
  logic sclk_fall;

  assign frame_active = !pin_q[PIN_CS];
  assign sclk_rise    = pin_q[PIN_SCLK] && !pin_prev_q[PIN_SCLK];
  assign sclk_fall    = !pin_q[PIN_SCLK] && pin_prev_q[PIN_SCLK];

  // ==========================================================================
  // Byte engine
  // ==========================================================================
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic        tx_bit;
  logic        tx_load;
  logic [15:0] tx_word;

  serial_byte_shifter #(
    .TX_W (16)
  ) u_shifter (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .frame_active (frame_active),
    .sclk_rise    (sclk_rise),
    .sclk_fall    (sclk_fall),
    .sdin_bit     (pin_q[PIN_SDIN]),
    .tx_load      (tx_load),
    .tx_word      (tx_word),
    .byte_done    (byte_done),
    .rx_byte      (rx_byte),
    .tx_bit       (tx_bit)
  );

  // ==========================================================================
  // Frame sequencing
  // ==========================================================================
  frame_state_t state_q;
  logic [7:0]   addr_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n || !frame_active) begin
      state_q <= ST_IDLE;
      addr_q  <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_ADDR;
        end
        ST_ADDR: begin
          if (byte_done) begin
            addr_q  <= rx_byte;
            state_q <= rx_byte[RD_FLAG_POS] ? ST_READ : ST_DATA;
          end
        end
        ST_DATA: begin
          if (byte_done) begin
            state_q <= ST_ADDR;
          end
        end
        ST_READ: begin
          state_q <= ST_READ;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  logic wr_strobe;

  assign wr_strobe = (state_q == ST_DATA) && byte_done;
  assign tx_load   = (state_q == ST_ADDR) && byte_done && rx_byte[RD_FLAG_POS];

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [HSHIFT_W-1:0] hshift_q;
  logic [VSHIFT_W-1:0] vshift_q;
  logic [2:0]          attr_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hshift_q <= HSHIFT_RESET;
    end else if (wr_strobe && addr_q == WR_HSHIFT) begin
      hshift_q <= rx_byte[HSHIFT_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      vshift_q <= VSHIFT_RESET;
    end else if (wr_strobe && addr_q == WR_VSHIFT) begin
      vshift_q <= rx_byte[VSHIFT_W-1:0];
    end
  end

  // A write that lands while the memory clear runs is dropped.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      eight_bit_mode_q <= MODE_RESET;
      attr_q           <= ATTR_RESET;
    end else if (wr_strobe && addr_q == WR_DMM && !dm_clear_busy) begin
      eight_bit_mode_q <= rx_byte[DMM_MODE_POS];
      attr_q           <= rx_byte[DMM_ATTR_HI:DMM_ATTR_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      local_background_bit_q <= 1'b0;
      blink_attr_bit_q       <= 1'b0;
      invert_attr_bit_q      <= 1'b0;
    end else begin
      local_background_bit_q <= attr_q[2];
      blink_attr_bit_q       <= attr_q[1];
      invert_attr_bit_q      <= attr_q[0];
    end
  end

  // ==========================================================================
  // Display memory write path
  // ==========================================================================
  logic [7:0] attr_byte;

  always_comb begin
    attr_byte               = 8'h00;
    attr_byte[ATTR_LBC_POS] = attr_q[2];
    attr_byte[ATTR_BLK_POS] = attr_q[1];
    attr_byte[ATTR_INV_POS] = attr_q[0];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dm_char_we_q   <= 1'b0;
      dm_attr_we_q   <= 1'b0;
      dm_char_data_q <= 8'h00;
      dm_attr_data_q <= 8'h00;
    end else begin
      dm_char_we_q <= 1'b0;
      dm_attr_we_q <= 1'b0;
      if (wr_strobe && addr_q == WR_DM_DATA) begin
        if (eight_bit_mode_q == MODE_16BIT) begin
          dm_char_we_q   <= 1'b1;
          dm_attr_we_q   <= 1'b1;
          dm_char_data_q <= rx_byte;
          dm_attr_data_q <= attr_byte;
        end else if (addr_high_byte_sel) begin
          dm_attr_we_q   <= 1'b1;
          dm_attr_data_q <= rx_byte;
        end else begin
          dm_char_we_q   <= 1'b1;
          dm_char_data_q <= rx_byte;
        end
      end
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    tx_word = 16'h0000;
    case (rx_byte)
      RD_HSHIFT: begin
        tx_word[15:8] = {2'b00, hshift_q};
      end
      RD_VSHIFT: begin
        tx_word[15:8] = {3'b000, vshift_q};
      end
      RD_DMM: begin
        tx_word[8+DMM_MODE_POS]               = eight_bit_mode_q;
        tx_word[8+DMM_ATTR_HI:8+DMM_ATTR_LO] = attr_q;
        tx_word[8+DMM_BUSY_POS]               = dm_clear_busy;
      end
      RD_DM_DATA: begin
        if (eight_bit_mode_q == MODE_16BIT) begin
          tx_word = {dm_rd_char, dm_rd_attr};
        end else begin
          tx_word[15:8] = addr_high_byte_sel ? dm_rd_attr : dm_rd_char;
        end
      end
      default: begin
        tx_word = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sdout_q      <= 1'b0;
      sdout_oe_n_q <= 1'b1;
    end else begin
      sdout_q      <= tx_bit;
      sdout_oe_n_q <= !(frame_active && state_q == ST_READ);
    end
  end

  // ==========================================================================
  // Overlay placement
  // ==========================================================================
  // Offsets are signed distances from the centre code, one unit per step.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      h_offset_px_q <= '0;
      v_offset_ln_q <= '0;
    end else begin
      h_offset_px_q <= signed'({1'b0, hshift_q} - HSHIFT_CENTRE);
      v_offset_ln_q <= signed'({1'b0, vshift_q} - VSHIFT_CENTRE);
    end
  end

  // Only horizontal blanking masks the overlay; vertical blanking lines may carry it.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      osd_pixel_en_q <= 1'b0;
    end else begin
      osd_pixel_en_q <= osd_pixel && !hblank;
    end
  end

endmodule : osd_offset_and_memory_mode_regs

// ===== hdl/osd_regs_pkg.sv
// Constants shared by the overlay offset and memory mode register block.
// Assumes a single 50 MHz core clock and a serial port with 8-bit address and data bytes.

package osd_regs_pkg;

  // ==========================================================================
  // Serial port addresses
  // ==========================================================================
  localparam logic [7:0] WR_HSHIFT   = 8'h02;
  localparam logic [7:0] RD_HSHIFT   = 8'h82;
  localparam logic [7:0] WR_VSHIFT   = 8'h03;
  localparam logic [7:0] RD_VSHIFT   = 8'h83;
  localparam logic [7:0] WR_DMM      = 8'h04;
  localparam logic [7:0] RD_DMM      = 8'h84;
  localparam logic [7:0] WR_DM_DATA  = 8'h07;
  localparam logic [7:0] RD_DM_DATA  = 8'hb0;
  localparam int         RD_FLAG_POS = 7;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int         HSHIFT_W      = 6;
  localparam int         VSHIFT_W      = 5;
  localparam logic [5:0] HSHIFT_RESET  = 6'h20;
  localparam logic [4:0] VSHIFT_RESET  = 5'h10;
  localparam logic [6:0] HSHIFT_CENTRE = 7'h20;
  localparam logic [5:0] VSHIFT_CENTRE = 6'h10;
  localparam int         DMM_MODE_POS  = 6;
  localparam int         DMM_ATTR_HI   = 5;
  localparam int         DMM_ATTR_LO   = 3;
  localparam int         DMM_BUSY_POS  = 2;
  localparam logic       MODE_RESET    = 1'b0;
  localparam logic [2:0] ATTR_RESET    = 3'h0;
  localparam logic       MODE_16BIT    = 1'b0;

  // Position of the copied attribute bits within the stored attribute byte.
  localparam int         ATTR_LBC_POS  = 7;
  localparam int         ATTR_BLK_POS  = 6;
  localparam int         ATTR_INV_POS  = 5;

  // ==========================================================================
  // Serial frame states
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_READ = 2'b11
  } frame_state_t;

  localparam int PIN_COUNT = 3;
  localparam int PIN_CS    = 0;
  localparam int PIN_SCLK  = 1;
  localparam int PIN_SDIN  = 2;

endpackage : osd_regs_pkg

// ===== hdl/serial_byte_shifter.sv
// Bit engine of the serial port: gathers bytes on rising clock edges and
// shifts a reply word out on falling edges.
// Assumes its inputs are already synchronised, edge-detected core clock pulses.

`timescale 1ns/100ps

module serial_byte_shifter #(
  parameter int TX_W = 16
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  // Synchronised pin events
  input  wire logic            frame_active,
  input  wire logic            sclk_rise,
  input  wire logic            sclk_fall,
  input  wire logic            sdin_bit,
  // Reply load
  input  wire logic            tx_load,
  input  wire logic [TX_W-1:0] tx_word,
  // Results
  output logic                 byte_done,
  output logic [7:0]           rx_byte,
  output logic                 tx_bit
);

  logic [2:0]      bit_cnt_q;
  logic [7:0]      rx_q;
  logic [TX_W-1:0] tx_q;
  logic            hold_q;

  // ==========================================================================
  // Receive side
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (!reset_n || !frame_active) begin
      bit_cnt_q <= 3'h0;
      rx_q      <= 8'h00;
      byte_done <= 1'b0;
    end else begin
      byte_done <= sclk_rise && (bit_cnt_q == 3'h7);
      if (sclk_rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        rx_q      <= {rx_q[6:0], sdin_bit};
      end
    end
  end

  assign rx_byte = rx_q;

  // ==========================================================================
  // Transmit side
  // ==========================================================================
  // The falling edge that ends the address byte must not shift the freshly
  // loaded reply, so the first fall after a load is skipped.
  always_ff @(posedge core_clk) begin
    if (!reset_n || !frame_active) begin
      tx_q   <= '0;
      hold_q <= 1'b0;
    end else if (tx_load) begin
      tx_q   <= tx_word;
      hold_q <= 1'b1;
    end else if (sclk_fall) begin
      if (hold_q) begin
        hold_q <= 1'b0;
      end else begin
        tx_q <= {tx_q[TX_W-2:0], 1'b0};
      end
    end
  end

  assign tx_bit = tx_q[TX_W-1];

endmodule : serial_byte_shifter

// ===== testbench/osd_regs_assertions.sv
// Checker for the offset and memory mode register block, watching its ports only.
// Assumes the bench binds it to the top module and keeps dm_clear_busy steady across frames.

`timescale 1ns/100ps

module osd_regs_checker (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset_n,
  // Watched ports
  input wire logic              cs_n,
  input wire logic              sdout_oe_n_q,
  input wire logic              dm_clear_busy,
  input wire logic              dm_char_we_q,
  input wire logic              dm_attr_we_q,
  input wire logic [7:0]        dm_attr_data_q,
  input wire logic              hblank,
  input wire logic              osd_pixel,
  input wire logic              osd_pixel_en_q,
  input wire logic signed [6:0] h_offset_px_q,
  input wire logic signed [5:0] v_offset_ln_q,
  input wire logic              eight_bit_mode_q,
  input wire logic              local_background_bit_q,
  input wire logic              blink_attr_bit_q,
  input wire logic              invert_attr_bit_q
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_NO_PIXEL_IN_BLANK: assert property (hblank |=> !osd_pixel_en_q)
    else $error("overlay pixel during blanking");
  AST_PIXEL_PASSES: assert property (osd_pixel && !hblank |=> osd_pixel_en_q)
    else $error("overlay pixel lost outside blanking");
  AST_H_RANGE: assert property (h_offset_px_q >= -7'sd32 && h_offset_px_q <= 7'sd31)
    else $error("horizontal offset out of range");
  AST_V_RANGE: assert property (v_offset_ln_q >= -6'sd16 && v_offset_ln_q <= 6'sd15)
    else $error("vertical offset out of range");
  AST_OE_IDLE: assert property (cs_n [*8] |-> sdout_oe_n_q)
    else $error("reply driven outside a frame");
  AST_PAIR_16: assert property (dm_char_we_q && !eight_bit_mode_q |-> dm_attr_we_q)
    else $error("attribute not written with character");
  AST_ATTR_COPY: assert property (dm_attr_we_q && !eight_bit_mode_q |->
      dm_attr_data_q == {local_background_bit_q, blink_attr_bit_q, invert_attr_bit_q, 5'h00})
    else $error("attribute byte not copied from mode");
  AST_ONE_BYTE_8: assert property (eight_bit_mode_q && (dm_char_we_q || dm_attr_we_q) |->
      dm_char_we_q != dm_attr_we_q)
    else $error("both bytes written in 8-bit mode");
  AST_WE_PULSE: assert property (dm_char_we_q |=> !dm_char_we_q)
    else $error("character strobe longer than one cycle");
  AST_MODE_HELD_BUSY: assert property (dm_clear_busy [*8] |=> $stable(eight_bit_mode_q))
    else $error("mode changed while clearing");
endmodule : osd_regs_checker

// ===== testbench/serial_host_model.sv
// Host side of the serial port: drives chip select, clock and data, samples replies.
// Assumes the bench calls frame from one process; timing is counted in core clock cycles.

`timescale 1ns/100ps

module serial_host_model (
  // Clock
  input wire logic   core_clk,
  // Serial pins
  output logic        cs_n,
  output logic        sclk,
  output logic        sdin,
  input  wire logic   sdout,
  // Read result
  output logic        rd_valid,
  output logic [15:0] rd_data
);
  // ==========================================================================
  // Bus cycles
  // ==========================================================================
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end

  task automatic wait_n(input int h);
    repeat (h) @(negedge core_clk);
  endtask : wait_n

  // Data changes while the clock is low; the reply is sampled just before each rise.
  task automatic bit_io(input logic b, input int h, output logic s);
    sdin = b;
    wait_n(h);
    s = sdout;
    sclk = 1'b1;
    wait_n(h);
    sclk = 1'b0;
  endtask : bit_io

  task automatic frame(input logic [7:0] a, input logic [7:0] d, input int nrd, input int h);
    logic [15:0] r;
    logic        s;
    r = 16'h0000;
    cs_n = 1'b0;
    wait_n(h);
    for (int i = 7; i >= 0; i--) bit_io(a[i], h, s);
    if (!a[7]) begin
      for (int i = 7; i >= 0; i--) bit_io(d[i], h, s);
    end else begin
      for (int i = 0; i < nrd; i++) begin
        bit_io(i[0], h, s);
        r = {r[14:0], s};
      end
    end
    wait_n(h);
    cs_n = 1'b1;
    // A released data line must not keep showing its last value.
    sdin = ~sdin;
    if (a[7]) begin
      rd_data = r;
      rd_valid = 1'b1;
    end
    wait_n(1);
    rd_valid = 1'b0;
    wait_n(h);
  endtask : frame
endmodule : serial_host_model

// ===== testbench/test_osd_offset_and_memory_mode_regs.sv
// Self-checking bench for the offset and memory mode register block.
// Assumes the host model on the serial pins and a random video and memory side.

`timescale 1ns/100ps

module test_osd_offset_and_memory_mode_regs;
  import osd_regs_pkg::*;

  logic               core_clk, reset_n, sdout_q, sdout_oe_n_q, rd_valid;
  logic               cs_n, sclk, sdin, dm_clear_busy, addr_high_byte_sel;
  logic [7:0]         dm_rd_char, dm_rd_attr, dm_char_data_q, dm_attr_data_q, code, d;
  logic               dm_char_we_q, dm_attr_we_q, hblank, osd_pixel, osd_pixel_en_q;
  logic signed [6:0]  h_offset_px_q;
  logic signed [5:0]  v_offset_ln_q;
  logic               eight_bit_mode_q, local_background_bit_q, blink_attr_bit_q;
  logic               invert_attr_bit_q;
  logic [15:0]        rd_data;
  logic [15:0]        q_rd[$];
  logic [17:0]        q_mem[$];
  logic [7:0]         tbl[4];
  int                 err_count, num_checks;
  int                 oe_cnt = 0;
  int                 oe_last = 0;

  serial_host_model host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdin(sdin),
    .sdout(sdout_q), .rd_valid(rd_valid), .rd_data(rd_data));

  osd_offset_and_memory_mode_regs uut (.core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n),
    .sclk(sclk), .sdin(sdin), .sdout_q(sdout_q), .sdout_oe_n_q(sdout_oe_n_q),
    .dm_clear_busy(dm_clear_busy), .addr_high_byte_sel(addr_high_byte_sel),
    .dm_rd_char(dm_rd_char), .dm_rd_attr(dm_rd_attr), .dm_char_we_q(dm_char_we_q),
    .dm_attr_we_q(dm_attr_we_q), .dm_char_data_q(dm_char_data_q),
    .dm_attr_data_q(dm_attr_data_q), .hblank(hblank), .osd_pixel(osd_pixel),
    .osd_pixel_en_q(osd_pixel_en_q), .h_offset_px_q(h_offset_px_q),
    .v_offset_ln_q(v_offset_ln_q), .eight_bit_mode_q(eight_bit_mode_q),
    .local_background_bit_q(local_background_bit_q), .blink_attr_bit_q(blink_attr_bit_q),
    .invert_attr_bit_q(invert_attr_bit_q));

  // ==========================================================================
  // Clock, stimulus helpers and result checks
  // ==========================================================================
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    hblank <= 1'($urandom);
    osd_pixel <= 1'($urandom);
  end

  // Counts cycles with the reply driver enabled, so each read can prove it was driven.
  always @(negedge core_clk) if (sdout_oe_n_q === 1'b0) oe_cnt <= oe_cnt + 1;

  task automatic fail(input string msg);
    err_count++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail

  task automatic check_rd();
    logic [15:0] e;
    num_checks++;
    e = q_rd.pop_front();
    if (rd_data !== e) fail($sformatf("read %h expected %h", rd_data, e));
    num_checks++;
    if (oe_cnt == oe_last) fail("reply output never enabled");
    oe_last = oe_cnt;
  endtask : check_rd

  task automatic check_mem();
    logic [17:0] e;
    num_checks++;
    e = q_mem.pop_front();
    if ({dm_char_we_q, dm_attr_we_q} !== e[17:16] ||
        (e[17] && dm_char_data_q !== e[15:8]) || (e[16] && dm_attr_data_q !== e[7:0]))
      fail($sformatf("memory write %b %h %h", e[17:16], dm_char_data_q, dm_attr_data_q));
  endtask : check_mem

  task automatic check_off(input logic [6:0] g, input logic [6:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("offset %h expected %h", g, e));
  endtask : check_off

  always @(posedge core_clk) if (rd_valid === 1'b1) check_rd();
  always @(negedge core_clk) if (dm_char_we_q === 1'b1 || dm_attr_we_q === 1'b1) check_mem();

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input int n);
    q_rd.push_back(e);
    host.frame(a, 8'h00, n, 8 + $urandom % 5);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.frame(a, v, 0, 8 + $urandom % 5);
  endtask : wr

  task automatic print_verdict();
    if (q_rd.size() != 0 || q_mem.size() != 0) fail("expected result never appeared");
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    #600us;
    fail("watchdog expired");
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    err_count = 0;
    num_checks = 0;
    reset_n = 1'b0;
    dm_clear_busy = 1'b0;
    addr_high_byte_sel = 1'b0;
    dm_rd_char = 8'h00;
    dm_rd_attr = 8'h00;
    void'($urandom(32'h2c30));
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    rd(RD_HSHIFT, 16'h0020, 8);
    rd(RD_VSHIFT, 16'h0010, 8);
    rd(RD_DMM, 16'h0000, 8);
    rd(8'h85, 16'h0000, 8);
    check_off(h_offset_px_q, 7'h00);
    tbl = '{8'h00, 8'h3f, 8'hff, 8'($urandom)};
    for (int i = 0; i < 4; i++) begin
      code = tbl[i];
      wr(WR_HSHIFT, code);
      check_off(h_offset_px_q, 7'({1'b0, code[5:0]} - 7'h20));
      rd(RD_HSHIFT, {10'h000, code[5:0]}, 8);
      wr(WR_VSHIFT, code);
      check_off({v_offset_ln_q[5], v_offset_ln_q}, 7'({2'b00, code[4:0]} - 7'h10));
      rd(RD_VSHIFT, {11'h000, code[4:0]}, 8);
    end
    wr(WR_DMM, 8'h38);
    rd(RD_DMM, 16'h0038, 8);
    dm_clear_busy = 1'b1;
    wr(WR_DMM, 8'h40);
    rd(RD_DMM, 16'h003c, 8);
    dm_clear_busy = 1'b0;
    d = 8'($urandom);
    q_mem.push_back({2'b11, d, 8'he0});
    wr(WR_DM_DATA, d);
    dm_rd_char = 8'($urandom);
    dm_rd_attr = 8'($urandom);
    rd(RD_DM_DATA, {dm_rd_char, dm_rd_attr}, 16);
    wr(WR_DMM, 8'h40);
    check_off({6'h00, eight_bit_mode_q}, 7'h01);
    for (int s = 0; s < 2; s++) begin
      addr_high_byte_sel = s[0];
      d = 8'($urandom);
      q_mem.push_back({~s[0], s[0], d, d});
      wr(WR_DM_DATA, d);
      rd(RD_DM_DATA, {8'h00, s[0] ? dm_rd_attr : dm_rd_char}, 8);
    end
    print_verdict();
  end
endmodule : test_osd_offset_and_memory_mode_regs

bind osd_offset_and_memory_mode_regs osd_regs_checker chk (.core_clk(core_clk),
  .reset_n(reset_n), .cs_n(cs_n), .sdout_oe_n_q(sdout_oe_n_q), .dm_clear_busy(dm_clear_busy),
  .dm_char_we_q(dm_char_we_q), .dm_attr_we_q(dm_attr_we_q), .dm_attr_data_q(dm_attr_data_q),
  .hblank(hblank), .osd_pixel(osd_pixel), .osd_pixel_en_q(osd_pixel_en_q),
  .h_offset_px_q(h_offset_px_q), .v_offset_ln_q(v_offset_ln_q),
  .eight_bit_mode_q(eight_bit_mode_q), .local_background_bit_q(local_background_bit_q),
  .blink_attr_bit_q(blink_attr_bit_q), .invert_attr_bit_q(invert_attr_bit_q));
